/* File: core/pmc_macrocells.sv */
// How it works
// - Three global modes apply to all cells
// - Register and complex select bits choose mode
// - Per-cell invert bit sets output polarity
// - Per-cell direction bit selects input or output
// - Two global plus sixteen cell bits configure
// - Registered: pin one clock, pin eleven enable
// - Complex: dedicated pins feed outer feedback paths
// - Complex: outer cells lose own pin feedback
// - Simple: feedback comes through neighbour cell
// - Simple: inner cells are outputs only
// - Transition variant sleeps without input change
// - Pin variant sleeps under power-down pin
// - Pin variant offers fifteen array inputs
// - Inputs and outputs latched while powered down
// - Registers cleared at power-on, preloadable
// - Eight output macrocells
// - Readable electronic signature held
// - Registered cells share clock and enable
// - Registered outputs eight terms, I/O seven
// - Complex: one product term drives enable
// - Simple: cell is input or always-on output
/*
 Top of the output macrocell section: mode decode, standby control,
 feedback routing into the array and eight cells. Assumes the product
 term array sits outside and hands in per-cell sums and enable terms;
 all pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_macrocells #(
    parameter int NUM_CELLS = `PMC_NUM_CELLS,
    parameter bit POWER_PIN_VARIANT = 1'b0,
    parameter logic [`PMC_SIG_WIDTH-1:0] SIGNATURE = `PMC_SIG_DEFAULT // Arbitrary value
) (
    input wire logic clk,
    input wire logic rstn,
    input wire pmc_pkg::pmc_cfg_t cfg,
    input wire logic clk_pin,
    input wire logic oe_pin_n,
    input wire logic powerdown_pin,
    input wire logic [`PMC_ARRAY_INPUTS-1:0] in_pins,
    input wire logic [NUM_CELLS-1:0] io_pins_in,
    input wire logic [NUM_CELLS-1:0] pt_sum,
    input wire logic [NUM_CELLS-1:0] pt_oe,
    input wire logic preload_en,
    input wire logic [NUM_CELLS-1:0] preload_val,
    output logic [NUM_CELLS-1:0] io_pins_out,
    output logic [NUM_CELLS-1:0] io_pins_oe,
    output logic [`PMC_ARRAY_INPUTS-1:0] array_in,
    output logic [NUM_CELLS-1:0] feedback,
    output logic [`PMC_ARRAY_INPUTS-1:0] array_in_valid,
    output logic [1:0] mode_out,
    output logic standby,
    output logic [`PMC_SIG_WIDTH-1:0] signature
);
    import pmc_pkg::*;

    localparam int INNER_LO = NUM_CELLS / 2 - 1; // Inner pair
    localparam int INNER_HI = NUM_CELLS / 2;
    localparam int PD_IDX = `PMC_PD_SLOT; // Input slot of the power-down pin

    // Reset release through two flops
    logic rst_s1_q, rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // Pin synchronisers: first stage read only by the second
    localparam int SYW = `PMC_ARRAY_INPUTS + NUM_CELLS + 3;
    logic [SYW-1:0] sy1_q, sy2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {clk_pin, oe_pin_n, powerdown_pin, io_pins_in, in_pins};
            sy2_q <= sy1_q;
        end
    end
    logic [`PMC_ARRAY_INPUTS-1:0] in_s;
    logic [NUM_CELLS-1:0] io_s;
    logic clk_s, oe_n_s, pd_s;
    assign {clk_s, oe_n_s, pd_s, io_s, in_s} = sy2_q;

    // Mode decode from the two global bits
    pmc_mode_t mode;
    always_comb begin
        case ({cfg.global_register_select_bit, cfg.global_complex_select_bit})
            2'b10, 2'b11: mode = PMC_MODE_REGISTERED;
            2'b01: mode = PMC_MODE_COMPLEX;
            default: mode = PMC_MODE_SIMPLE;
        endcase
    end

    // Shared clock edge detect on the synchronised pin
    // Previous sample resets low, like the idle pin, so reset gives no
    // false capture edge
    logic clk_prev_q, clk_prev_d;
    logic reg_edge;
    always_comb begin
        clk_prev_d = clk_s;
    end
    assign reg_edge = clk_s & ~clk_prev_q;

    // Standby control: transition detect or power-down pin
    // Limitation: any quiet cycle sleeps, so a wake lasts only while inputs keep changing
    logic standby_q, standby_d;
    logic [`PMC_ARRAY_INPUTS+NUM_CELLS-1:0] act_prev_q, act_prev_d;
    logic activity;
    always_comb begin
        act_prev_d = {io_s, in_s};
        activity = ({io_s, in_s} != act_prev_q) || (clk_s != clk_prev_q);
        if (POWER_PIN_VARIANT) begin
            standby_d = pd_s;
        end else begin
            standby_d = !activity;
        end
    end

    // Array inputs and feedback, latched during standby
    logic [`PMC_ARRAY_INPUTS-1:0] arr_q, arr_d, arrv_q, arrv_d;
    logic [NUM_CELLS-1:0] fb_q, fb_d;
    // Register state of each cell, read by the registered feedback
    logic [NUM_CELLS-1:0] cells_reg;
    always_comb begin
        arr_d = arr_q;
        fb_d = fb_q;
        arrv_d = '1;
        if (POWER_PIN_VARIANT) begin
            arrv_d[PD_IDX] = 1'b0;
        end
        if (!standby_q) begin
            arr_d = in_s;
            if (POWER_PIN_VARIANT) begin
                arr_d[PD_IDX] = 1'b0;
            end
            case (mode)
                PMC_MODE_REGISTERED: begin
                    // Own pin, or register state when registered
                    for (int i = 0; i < NUM_CELLS; i++) begin
                        fb_d[i] = cfg.cell_direction_bit[i] ? io_s[i] : cells_reg[i];
                    end
                end
                PMC_MODE_COMPLEX: begin
                    fb_d = io_s;
                    fb_d[NUM_CELLS-1] = clk_s;
                    // The pin is a plain input now: its level goes in as is
                    fb_d[0] = oe_n_s;
                end
                PMC_MODE_SIMPLE: begin
                    // Neighbour routing; inner pair carries none
                    for (int i = 0; i < NUM_CELLS; i++) begin
                        fb_d[i] = (i < INNER_LO) ? io_s[i+1] : (i > INNER_HI) ? io_s[i-1] : 1'b0;
                    end
                    fb_d[INNER_LO] = 1'b0;
                    fb_d[INNER_HI] = 1'b0;
                end
                default: fb_d = '0;
            endcase
        end
    end

    // Status flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_q <= 1'b0;
            act_prev_q <= '0;
            standby_q <= 1'b0;
            arr_q <= '0;
            arrv_q <= '0;
            fb_q <= '0;
        end else begin
            clk_prev_q <= clk_prev_d;
            act_prev_q <= act_prev_d;
            standby_q <= standby_d;
            arr_q <= arr_d;
            arrv_q <= arrv_d;
            fb_q <= fb_d;
        end
    end

    // Eight cells, one per output pin
    logic [NUM_CELLS-1:0] cells_out, cells_oe;
    for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
        pmc_cell u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .mode(mode),
            .reg_edge(reg_edge),
            .shared_oe(~oe_n_s),
            .freeze(standby_q),
            .pt_sum(pt_sum[g]),
            .pt_oe(pt_oe[g]),
            .invert(cfg.polarity_invert_bit[g]),
            .is_input(cfg.cell_direction_bit[g]),
            .no_input(g == INNER_LO || g == INNER_HI),
            .preload_en(preload_en),
            .preload_val(preload_val[g]),
            .pin_out(cells_out[g]),
            .pin_oe(cells_oe[g]),
            .reg_val(cells_reg[g])
        );
    end

    // Outputs straight from flops
    logic [1:0] mode_q;
    logic [`PMC_SIG_WIDTH-1:0] sig_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 2'h0;
            sig_q <= '0;
        end else begin
            mode_q <= mode;
            sig_q <= SIGNATURE;
        end
    end

    assign io_pins_out = cells_out;
    assign io_pins_oe = cells_oe;
    assign array_in = arr_q;
    assign array_in_valid = arrv_q;
    assign feedback = fb_q;
    assign mode_out = mode_q;
    assign standby = standby_q;
    assign signature = sig_q;

    // Pin variant request: the synchronised pin level
    sequence s_pd_high;
        POWER_PIN_VARIANT && pd_s;
    endsequence

    a_standby_pin: assert property (@(posedge clk) disable iff (!rst_n)
        s_pd_high |=> standby_q)
        else $error("Power-down pin did not enter standby");
    a_standby_itd: assert property (@(posedge clk) disable iff (!rst_n)
        !POWER_PIN_VARIANT && activity |=> !standby_q)
        else $error("Transition did not wake");
    a_freeze_fb: assert property (@(posedge clk) disable iff (!rst_n)
        standby_q |=> $stable(fb_q) && $stable(arr_q))
        else $error("Latched values moved in standby");
    a_complex_outer: assert property (@(posedge clk) disable iff (!rst_n)
        !standby_q && mode == PMC_MODE_COMPLEX |=> fb_q[NUM_CELLS-1] == $past(clk_s))
        else $error("Outer feedback not dedicated input");
    a_simple_inner: assert property (@(posedge clk) disable iff (!rst_n)
        !standby_q && mode == PMC_MODE_SIMPLE |=> !fb_q[INNER_LO] && !fb_q[INNER_HI])
        else $error("Inner cell gave feedback");
    a_pd_excluded: assert property (@(posedge clk) disable iff (!rst_n)
        POWER_PIN_VARIANT |=> !arrv_q[PD_IDX] && !arr_q[PD_IDX])
        else $error("Power-down pin reached array");
    a_mode_decode: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.global_register_select_bit |=> mode_q == 2'(PMC_MODE_REGISTERED))
        else $error("Register select did not give registered mode");
    a_sig_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> sig_q == SIGNATURE)
        else $error("Signature wrong");

    // Complex mode: the enable pin rides the lowest cell's feedback path
    a_complex_oe_fb: assert property (@(posedge clk) disable iff (!rst_n)
        !standby_q && mode == PMC_MODE_COMPLEX |=> fb_q[0] == $past(oe_n_s))
        else $error("Enable pin not on outer feedback");

    // Simple mode: outer paths carry the neighbouring pin
    a_simple_nbr: assert property (@(posedge clk) disable iff (!rst_n)
        !standby_q && mode == PMC_MODE_SIMPLE |=> fb_q[0] == $past(io_s[1]) && fb_q[NUM_CELLS-1] == $past(io_s[NUM_CELLS-2]))
        else $error("Simple feedback not from neighbour");

    // Registered mode: an I/O cell feeds back its own pin
    a_reg_fb_own: assert property (@(posedge clk) disable iff (!rst_n)
        !standby_q && mode == PMC_MODE_REGISTERED && cfg.cell_direction_bit[0] |=> fb_q[0] == $past(io_s[0]))
        else $error("I/O cell feedback not from its pin");

    // Transition variant falls asleep on a quiet cycle
    a_itd_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        !POWER_PIN_VARIANT && !activity |=> standby_q)
        else $error("Quiet inputs did not enter standby");

    // Pin variant ignores activity: only the pin puts it to sleep
    a_pin_wake: assert property (@(posedge clk) disable iff (!rst_n)
        POWER_PIN_VARIANT && !pd_s |=> !standby_q)
        else $error("Standby without power-down pin");

    // Complex select alone gives complex mode
    a_complex_decode: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.global_register_select_bit && cfg.global_complex_select_bit |=> mode_q == 2'(PMC_MODE_COMPLEX))
        else $error("Complex select did not give complex mode");

    // Both select bits low give simple mode
    a_simple_decode: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.global_register_select_bit && !cfg.global_complex_select_bit |=> mode_q == 2'(PMC_MODE_SIMPLE))
        else $error("Clear select bits did not give simple mode");

    // One capture per pin rise, never a held strobe
    a_edge_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        reg_edge |=> !reg_edge)
        else $error("Capture strobe longer than one cycle");

    // Transition variant keeps every array input usable
    a_valid_full: assert property (@(posedge clk) disable iff (!rst_n)
        !POWER_PIN_VARIANT |=> arrv_q == '1)
        else $error("Array input marked unusable");
endmodule : pmc_macrocells

/* File: common/pmc_consts.svh */
/*
 Holds the constants of the macrocell block: counts, the power-down input
 slot and the signature width and default value. Included by the package
 and by the design files.
*/
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_NUM_CELLS 8
`define PMC_NUM_CELL_BITS 16
`define PMC_PT_PER_CELL 8
`define PMC_PT_IO_CELL 7
`define PMC_ARRAY_INPUTS 16
`define PMC_ARRAY_INPUTS_PPIN 15
`define PMC_PD_SLOT 3
`define PMC_SIG_WIDTH 64
`define PMC_SIG_DEFAULT 64'h0123_4567_89ab_cdef
`endif

/* File: common/pmc_pkg.sv */
/*
 Types of the macrocell block: the global mode and the per-cell config.
 Assumes pmc_consts.svh is on the include path.
*/
`include "pmc_consts.svh"
package pmc_pkg;
    // Global operating mode shared by all cells
    typedef enum logic [1:0] {
        PMC_MODE_SIMPLE,
        PMC_MODE_COMPLEX,
        PMC_MODE_REGISTERED
    } pmc_mode_t;

    // Full architecture configuration: two global bits and per-cell bits
    typedef struct packed {
        logic global_register_select_bit;
        logic global_complex_select_bit;
        logic [`PMC_NUM_CELLS-1:0] polarity_invert_bit;
        logic [`PMC_NUM_CELLS-1:0] cell_direction_bit;
    } pmc_cfg_t;

    // One cell's pin drive
    typedef struct packed {
        logic out_val;
        logic out_en;
    } pmc_pin_t;
endpackage : pmc_pkg

/* File: core/pmc_cell.sv */
/*
 One output macrocell: register with preload, polarity and output enable.
 Assumes the top supplies a synchronised clock-edge enable and the mode.
*/
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_cell (
    input wire logic clk,
    input wire logic rst_n,
    input wire pmc_pkg::pmc_mode_t mode,
    input wire logic reg_edge,
    input wire logic shared_oe,
    input wire logic freeze,
    input wire logic pt_sum,
    input wire logic pt_oe,
    input wire logic invert,
    input wire logic is_input,
    input wire logic no_input,
    input wire logic preload_en,
    input wire logic preload_val,
    output logic pin_out,
    output logic pin_oe,
    output logic reg_val
);
    import pmc_pkg::*;

    logic reg_q, reg_d; // Cell register
    logic out_d, oe_d; // Next pin drive
    logic out_q, oe_q;

    // Register next value: preload beats clock and freeze, freeze holds against the clock
    always_comb begin
        reg_d = reg_q;
        if (preload_en) begin
            reg_d = preload_val;
        end else if (!freeze && reg_edge && mode == PMC_MODE_REGISTERED && !is_input) begin
            reg_d = pt_sum;
        end
    end

    // Pin drive per mode; latched while frozen
    always_comb begin
        out_d = out_q;
        oe_d = oe_q;
        if (!freeze) begin
            case (mode)
                PMC_MODE_REGISTERED: begin
                    out_d = (is_input ? pt_sum : reg_q) ^ invert;
                    oe_d = is_input ? pt_oe : shared_oe;
                end
                PMC_MODE_COMPLEX: begin
                    out_d = pt_sum ^ invert;
                    oe_d = pt_oe;
                end
                PMC_MODE_SIMPLE: begin
                    out_d = pt_sum ^ invert;
                    // Inner cells cannot be inputs
                    oe_d = no_input | !is_input;
                end
                default: begin
                    out_d = 1'b0;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Registers cleared at power-on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            reg_q <= reg_d;
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign reg_val = reg_q;

    a_cell_preload: assert property (@(posedge clk) disable iff (!rst_n)
        preload_en |=> reg_q == $past(preload_val))
        else $error("Preload value not taken");
endmodule : pmc_cell

/* File: dv/pmc_board.sv */
/*
 Board model around the macrocell block: makes shared clock pin pulses
 and resolves the eight two-way pins.
 Assumes requests arrive as one-cycle strobes on the bench clock.
*/
`timescale 1ns/1ps
module pmc_board (
    input wire logic clk,
    input wire logic fire,
    input wire logic [7:0] io_pins_out,
    input wire logic [7:0] io_pins_oe,
    input wire logic [7:0] board_val,
    output logic clk_pin,
    output logic [7:0] io_pins_in
);
    int cnt = 0; // Pulse phase counter

    // Six high then six low, far above the two-cycle minimum
    always @(posedge clk) begin
        if (fire && cnt == 0) begin
            cnt <= 12;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign clk_pin = (cnt > 6);

    // Board drives a pin only where the device has let go of it
    assign io_pins_in = (io_pins_oe & io_pins_out) | (~io_pins_oe & board_val);
endmodule : pmc_board

/* File: dv/test_pmc_macrocells.sv */
/*
 Self-checking bench for the macrocell section: both standby variants,
 all three modes, preload, capture, polarity and feedback routing.
 Assumes the board model in pmc_board.sv and the package on the path.
*/
`timescale 1ns/1ps
`include "pmc_consts.svh"
module test_pmc_macrocells;
    import pmc_pkg::*;
    localparam logic [63:0] SIG = 64'h5a5a_0f0f_3c3c_9696; // Arbitrary value
    logic clk = 1'b0;
    logic rstn = 1'b0;
    pmc_cfg_t cfg = '0;
    logic clk_pin, oe_pin_n = 1'b1, powerdown_pin = 1'b0, preload_en = 1'b0;
    logic fire = 1'b0, tog_en = 1'b1; // Tog keeps the sleepy variant awake
    logic [15:0] in_pins = '0, arr, arr_v, pp_arr, pp_arr_v, saved;
    logic [7:0] io_in, board_val = '0, pt_sum = '0, pt_oe = '0, preload_val = '0;
    logic [7:0] io_out, io_oe, fb;
    logic [1:0] mode_out;
    logic standby, pp_standby;
    logic [63:0] signature;
    int num_errors = 0, cmp_count = 0;

    // Free running clock
    always #10 clk = ~clk;

    // Spare input toggles so activity is seen each cycle
    always @(posedge clk) if (tog_en) in_pins[15] <= ~in_pins[15];

    pmc_macrocells #(.SIGNATURE(SIG)) pmc_macrocells_inst (.clk(clk), .rstn(rstn), .cfg(cfg),
        .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .powerdown_pin(powerdown_pin),
        .in_pins(in_pins), .io_pins_in(io_in), .pt_sum(pt_sum), .pt_oe(pt_oe),
        .preload_en(preload_en), .preload_val(preload_val), .io_pins_out(io_out),
        .io_pins_oe(io_oe), .array_in(arr), .feedback(fb), .array_in_valid(arr_v),
        .mode_out(mode_out), .standby(standby), .signature(signature));
    // Power pin variant shares every input
    pmc_macrocells #(.POWER_PIN_VARIANT(1'b1)) pmc_macrocells_pp_inst (.clk(clk), .rstn(rstn),
        .cfg(cfg), .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .powerdown_pin(powerdown_pin),
        .in_pins(in_pins), .io_pins_in(io_in), .pt_sum(pt_sum), .pt_oe(pt_oe),
        .preload_en(preload_en), .preload_val(preload_val), .io_pins_out(),
        .io_pins_oe(), .array_in(pp_arr), .feedback(), .array_in_valid(pp_arr_v),
        .mode_out(), .standby(pp_standby), .signature());
    pmc_board pmc_board_inst (.clk(clk), .fire(fire), .io_pins_out(io_out),
        .io_pins_oe(io_oe), .board_val(board_val), .clk_pin(clk_pin), .io_pins_in(io_in));

    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    // Single exit point
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // Register select wins over complex select
    function automatic logic [1:0] exp_mode(input logic r, input logic c);
        return r ? 2'h2 : (c ? 2'h1 : 2'h0);
    endfunction : exp_mode

    // Registered mode: register cells show the register, I/O cells the sum
    function automatic logic [7:0] exp_reg_out(input logic [7:0] regv, input logic [7:0] sum,
        input pmc_cfg_t c);
        return ((regv & ~c.cell_direction_bit) | (sum & c.cell_direction_bit)) ^ c.polarity_invert_bit;
    endfunction : exp_reg_out

    // Hang guard, far beyond the expected run
    initial begin
        step(5000);
        num_errors++;
        close_out();
    end

    initial begin
        void'($urandom(18219));
        step(3);
        check(io_oe, 8'h00);
        check(io_out, 8'h00);
        rstn <= 1'b1;
        step(4);
        check(signature, SIG);
        check({pp_arr_v[3], pp_arr[3]}, 2'b00);
        // Every mode encoding
        for (int m = 0; m < 4; m++) begin
            cfg <= {m[1], m[0], 16'h0000};
            step(5);
            check(mode_out, exp_mode(m[1], m[0]));
        end
        // Registered: preload, then capture on the shared clock pin
        oe_pin_n <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            cfg <= {2'b10, 8'($urandom), 8'($urandom)};
            preload_val <= 8'($urandom);
            preload_en <= 1'b1;
            step(1);
            preload_en <= 1'b0;
            step(6);
            check(io_out, exp_reg_out(preload_val, pt_sum, cfg));
            check(io_oe, 8'(~cfg.cell_direction_bit));
            pt_sum <= 8'($urandom);
            fire <= 1'b1;
            step(1);
            fire <= 1'b0;
            step(10);
            check(io_out, pt_sum ^ cfg.polarity_invert_bit);
        end
        oe_pin_n <= 1'b1;
        step(5);
        check(io_oe, 8'h00);
        // Simple: inputs feed neighbours, inner pair always drives
        for (int k = 0; k < 4; k++) begin
            cfg <= {2'b00, 8'h00, 8'hff};
            board_val <= 8'($urandom);
            step(6);
            check(io_oe, 8'h18);
            check({fb[7:6], fb[1:0]}, {board_val[6:5], board_val[2:1]});
            cfg <= {2'b00, 8'($urandom), 8'h00};
            pt_sum <= 8'($urandom);
            step(5);
            check(io_oe, 8'hff);
            check(io_out, pt_sum ^ cfg.polarity_invert_bit);
        end
        // Complex: enable term per cell, dedicated pins on outer paths
        cfg <= {2'b01, 16'h0000};
        for (int k = 0; k < 4; k++) begin
            pt_oe <= 8'($urandom);
            oe_pin_n <= 1'($urandom);
            fire <= 1'b1;
            step(1);
            fire <= 1'b0;
            step(5);
            check(io_oe, pt_oe);
            check({fb[7], fb[0]}, {1'b1, oe_pin_n});
            step(8);
        end
        // Standby by inactivity, then power pin with latched inputs
        tog_en <= 1'b0;
        step(8);
        check(standby, 1'b1);
        powerdown_pin <= 1'b1;
        step(6);
        check(pp_standby, 1'b1);
        saved = pp_arr;
        in_pins[7:0] <= 8'($urandom) | 8'h01;
        step(4);
        check(standby, 1'b0);
        step(2);
        check(pp_arr, saved);
        powerdown_pin <= 1'b0;
        step(6);
        check(pp_standby, 1'b0);
        check(pp_arr[7:0], in_pins[7:0] & 8'hf7);
        check(arr[7:0], in_pins[7:0]);
        check(arr_v, 16'hffff);
        close_out();
    end
endmodule : test_pmc_macrocells
